// *** core/asl_core.sv ***
// Program counter, loops and X/Y data address generation
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Program counter is 23 bits wide
// - Instruction words are 24 bits wide
// - Flow, double move, window, table add cycles
// - Loops zero overhead, interruptible every iteration
// - Sixteen 16-bit registers: data, pointer, offset
// - Last register is hardware stack pointer
// - Base data space is 32K words
// - General accesses use X generator, linear
// - Upper data half maps into program space
// - Page select extends address to 8M words
// - Modulo addressing on X and Y
// - Bit reversal only on X writes
// - No DSP means no modulo, bit reversal
// - Eight operand addressing modes supported
// - Program word: even low, odd upper half
// - Program counter steps by two
// - Addresses below 0x200 hold vectors
// - Execution starts at address zero
// - X read bus carries combined reads except window reads
// - Multiply class reads Y concurrently
// - All writes use combined space, fixed boundary
module asl_core
#(
    parameter bit HAS_DSP = 1'b1,
    parameter logic [15:0] Y_BASE = asl_pkg::Y_BASE_DEF
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    // Fetch side
    input wire logic fetch_en,
    input wire logic pc_load,
    input wire logic [22:0] pc_target,
    input wire logic slow_op,
    input wire logic irq_take,
    input wire logic [7:0] irq_vec,
    input wire logic loop_start,
    input wire logic [22:0] loop_end,
    input wire logic [15:0] loop_count,
    input wire logic rpt_start,
    input wire logic [15:0] rpt_count,
    input wire logic sp_push,
    output logic [22:0] prog_addr,
    output logic prog_rd,
    input wire logic [23:0] prog_rdata,
    output logic [23:0] instr_word,
    output logic instr_valid,
    output logic [15:0] stack_addr,
    // Operand side
    input wire logic dacc_req,
    input wire logic dacc_we,
    input wire logic [2:0] dacc_mode,
    input wire logic [3:0] dacc_reg,
    input wire logic [15:0] dacc_lit,
    input wire logic [15:0] dacc_wdata,
    input wire logic dacc_mac,
    input wire logic [3:0] dacc_yreg,
    input wire logic reg_we,
    input wire logic [3:0] reg_wsel,
    input wire logic [15:0] reg_wdata,
    // Window, paging and circular controls
    input wire logic win_en,
    input wire logic [7:0] win_page,
    input wire logic [8:0] read_page_select,
    input wire logic [8:0] write_page_select,
    input wire logic mod_en,
    input wire logic [15:0] mod_start,
    input wire logic [15:0] mod_end,
    input wire logic brev_en,
    input wire logic [15:0] brev_mod,
    // Memory side
    output logic [23:0] x_raddr,
    output logic x_rd,
    output logic [23:0] x_waddr,
    output logic x_wr,
    output logic [15:0] x_wdata,
    output logic [15:0] y_raddr,
    output logic y_rd,
    output logic y_range_err,
    output logic [15:0] win_data,
    output logic win_valid,
    output logic [15:0] operand,
    output logic dacc_busy
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Reverse the bits of a 16-bit word
    function automatic logic [15:0] rev16(input logic [15:0] a);
        for (int i = 0; i < 16; i++)
            rev16[i] = a[15-i];
    endfunction

    // Circular step within start..end, wrapping at either edge
    function automatic logic [15:0] mod_step(input logic [15:0] a,
        input logic down, input logic [15:0] lo, input logic [15:0] hi);
        if (down)
            mod_step = (a == lo) ? hi : a - asl_pkg::WORD_STEP;
        else
            mod_step = (a == hi) ? lo : a + asl_pkg::WORD_STEP;
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    asl_wreg_if rf ();
    asl_wreg u_wreg
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .rf(rf)
    );

    // ------------------------------------------------------------
    // Program counter and loops
    // ------------------------------------------------------------
    logic [22:0] pc_q, pc_d; // Current fetch address
    logic [1:0] stall_q; // Extra cycles still owed
    logic [15:0] lcnt_q; // Block loop iterations left
    logic [22:0] ltop_q, lend_q; // Block loop bounds
    logic [15:0] rcnt_q; // Single-instruction repeats left
    logic win_busy; // Window read owns the program port
    wire stalled = (stall_q != 2'h0) || win_busy;
    wire at_lend = (lcnt_q != asl_pkg::ZERO_W) && (pc_q == lend_q);
    wire rpt_act = (rcnt_q != asl_pkg::ZERO_W);
    wire [22:0] vec_addr = {14'h0000, irq_vec, 1'b0}
        & (asl_pkg::VEC_END - 23'h000001);
    wire advance = fetch_en && !stalled;

    // Next program counter, interrupt first, then loads
    always_comb
    begin
        pc_d = pc_q;
        if (irq_take)
            pc_d = vec_addr;
        else if (pc_load)
            pc_d = pc_target;
        else if (advance && at_lend)
            pc_d = ltop_q;
        else if (advance && !rpt_act)
            pc_d = pc_q + asl_pkg::PC_STEP;
    end

    // Counter, stall and loop bookkeeping
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pc_q <= asl_pkg::PC_RESET;
            stall_q <= 2'h0;
            lcnt_q <= asl_pkg::ZERO_W;
            ltop_q <= asl_pkg::PC_RESET;
            lend_q <= asl_pkg::PC_RESET;
            rcnt_q <= asl_pkg::ZERO_W;
        end
        else
        begin
            pc_q <= pc_d;
            if (slow_op || pc_load || irq_take)
                stall_q <= asl_pkg::EXTRA_CYC;
            else if (stall_q != 2'h0)
                stall_q <= stall_q - 2'h1;
            if (loop_start)
            begin
                lcnt_q <= loop_count;
                ltop_q <= pc_q + asl_pkg::PC_STEP;
                lend_q <= loop_end;
            end
            else if (advance && at_lend)
                lcnt_q <= lcnt_q - 16'h0001;
            if (rpt_start)
                rcnt_q <= rpt_count;
            else if (advance && rpt_act)
                rcnt_q <= rcnt_q - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Operand pipeline: select register, then issue address
    // ------------------------------------------------------------
    asl_pkg::asl_state_t st_q;
    logic we_q, mac_q;
    logic [2:0] mode_q;
    logic [3:0] reg_q;
    logic [15:0] lit_q, wd_q;
    wire take = dacc_req && (st_q == asl_pkg::ASL_IDLE);
    assign rf.xsel = take ? dacc_reg : reg_q;
    assign rf.ysel = dacc_yreg;
    wire [15:0] ptr = rf.xval;
    wire is_ind = (mode_q >= 3'(asl_pkg::ASL_INDIRECT));
    wire [15:0] ea = (mode_q == 3'(asl_pkg::ASL_DIRECT)) ? lit_q
        : (mode_q == 3'(asl_pkg::ASL_RELATIVE)) ? ptr + lit_q : ptr;
    wire mem_mode = is_ind || (mode_q == 3'(asl_pkg::ASL_DIRECT))
        || (mode_q == 3'(asl_pkg::ASL_RELATIVE));
    wire post = (mode_q == 3'(asl_pkg::ASL_IND_POSTINC))
        || (mode_q == 3'(asl_pkg::ASL_IND_POSTDEC));
    wire down = (mode_q == 3'(asl_pkg::ASL_IND_POSTDEC));
    // Circular and reversed only with DSP
    wire mod_on = HAS_DSP && mod_en;
    wire brev_on = HAS_DSP && brev_en && we_q;
    wire [15:0] xnext = brev_on ? rev16(rev16(ptr) + rev16(brev_mod))
        : mod_on ? mod_step(ptr, down, mod_start, mod_end)
        : down ? ptr - asl_pkg::WORD_STEP : ptr + asl_pkg::WORD_STEP;
    wire [15:0] ynext = mod_on
        ? mod_step(rf.yval, 1'b0, mod_start, mod_end)
        : rf.yval + asl_pkg::WORD_STEP;
    // Upper half redirected into program space
    wire in_win = win_en && ea[asl_pkg::WIN_BIT];
    wire [22:0] win_addr = {win_page, ea[14:0]};
    wire [23:0] rd_ext = ea[asl_pkg::WIN_BIT]
        ? {read_page_select, ea[14:0]} : {8'h00, ea};
    wire [23:0] wr_ext = ea[asl_pkg::WIN_BIT]
        ? {write_page_select, ea[14:0]} : {8'h00, ea};
    // Y operand must lie in Y range
    wire y_ok = (rf.yval >= Y_BASE);
    wire issue = (st_q == asl_pkg::ASL_ISSUE);
    assign win_busy = issue && in_win && mem_mode && !we_q;

    // Sequence one access at a time
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_q <= asl_pkg::ASL_IDLE;
            we_q <= 1'b0;
            mac_q <= 1'b0;
            mode_q <= 3'h0;
            reg_q <= 4'h0;
            lit_q <= asl_pkg::ZERO_W;
            wd_q <= asl_pkg::ZERO_W;
        end
        else
        begin
            case (st_q)
                asl_pkg::ASL_IDLE:
                begin
                    if (dacc_req)
                    begin
                        st_q <= asl_pkg::ASL_RDREG;
                        we_q <= dacc_we;
                        mac_q <= dacc_mac && HAS_DSP;
                        mode_q <= dacc_mode;
                        reg_q <= dacc_reg;
                        lit_q <= dacc_lit;
                        wd_q <= dacc_wdata;
                    end
                end
                asl_pkg::ASL_RDREG:
                    st_q <= asl_pkg::ASL_ISSUE;
                asl_pkg::ASL_ISSUE:
                    st_q <= asl_pkg::ASL_IDLE;
                default:
                    st_q <= asl_pkg::ASL_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register write port: pointer updates, stack, execution unit
    // ------------------------------------------------------------
    wire ptr_upd = issue && post;
    wire y_upd = issue && mac_q;
    assign rf.we = ptr_upd || y_upd || sp_push || reg_we;
    assign rf.wsel = ptr_upd ? reg_q : y_upd ? dacc_yreg
        : sp_push ? asl_pkg::SP_IDX : reg_wsel;
    assign rf.wdata = ptr_upd ? xnext : y_upd ? ynext
        : sp_push ? rf.spval + asl_pkg::WORD_STEP : reg_wdata;

    // ------------------------------------------------------------
    // Memory strobes and addresses, all from flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            x_raddr <= 24'h000000;
            x_rd <= 1'b0;
            x_waddr <= 24'h000000;
            x_wr <= 1'b0;
            x_wdata <= asl_pkg::ZERO_W;
            y_raddr <= asl_pkg::ZERO_W;
            y_rd <= 1'b0;
            y_range_err <= 1'b0;
            operand <= asl_pkg::ZERO_W;
            dacc_busy <= 1'b0;
            stack_addr <= asl_pkg::ZERO_W;
        end
        else
        begin
            // Every read except window reads on X read bus
            x_rd <= issue && mem_mode && !we_q && !in_win;
            x_raddr <= rd_ext;
            x_wr <= issue && mem_mode && we_q;
            x_waddr <= wr_ext;
            x_wdata <= wd_q;
            y_rd <= issue && mac_q && y_ok;
            y_raddr <= rf.yval;
            y_range_err <= issue && mac_q && !y_ok;
            operand <= (mode_q == 3'(asl_pkg::ASL_LITERAL)) ? lit_q : ptr;
            dacc_busy <= (st_q != asl_pkg::ASL_IDLE) || dacc_req;
            stack_addr <= rf.spval;
        end
    end

    // ------------------------------------------------------------
    // Program port: fetch or window read
    // ------------------------------------------------------------
    logic win_pend_q, win_odd_q;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            prog_addr <= asl_pkg::PC_RESET;
            prog_rd <= 1'b0;
            instr_word <= 24'h000000;
            instr_valid <= 1'b0;
            win_pend_q <= 1'b0;
            win_odd_q <= 1'b0;
            win_data <= asl_pkg::ZERO_W;
            win_valid <= 1'b0;
        end
        else
        begin
            // Window read steals a fetch slot
            prog_rd <= win_busy || advance;
            prog_addr <= win_busy ? {win_addr[22:1], 1'b0} : pc_q;
            win_pend_q <= win_busy;
            win_odd_q <= win_addr[0];
            instr_word <= prog_rdata;
            instr_valid <= prog_rd && !win_pend_q;
            win_data <= win_odd_q ? {8'h00, prog_rdata[23:16]}
                : prog_rdata[15:0];
            win_valid <= prog_rd && win_pend_q;
        end
    end
endmodule
`default_nettype wire

// *** pkg/asl_pkg.sv ***
// Shared constants and types for the core address space logic
package asl_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PC_W = 23;
    localparam int IW_W = 24;
    localparam int DW = 16;
    localparam int NREG = 16;
    localparam int RSEL_W = 4;
    localparam int PAGE_W = 9;
    localparam int WIN_BIT = 15;
    localparam int VEC_W = 8;
    // ------------------------------------------------------------
    // Fixed addresses and steps
    // ------------------------------------------------------------
    localparam logic [PC_W-1:0] PC_RESET = 23'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 23'h000002;
    localparam logic [PC_W-1:0] VEC_END = 23'h000200;
    localparam logic [PC_W-1:0] START_PTR = 23'h000002;
    localparam logic [RSEL_W-1:0] SP_IDX = 4'hf;
    localparam logic [DW-1:0] WORD_STEP = 16'h0002;
    localparam logic [DW-1:0] Y_BASE_DEF = 16'h9000;
    localparam logic [1:0] EXTRA_CYC = 2'h1;
    localparam logic [DW-1:0] ZERO_W = 16'h0000;
    // ------------------------------------------------------------
    // Operand addressing modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ASL_INHERENT = 3'h0,
        ASL_RELATIVE = 3'h1,
        ASL_LITERAL = 3'h2,
        ASL_DIRECT = 3'h3,
        ASL_REGDIR = 3'h4,
        ASL_INDIRECT = 3'h5,
        ASL_IND_POSTINC = 3'h6,
        ASL_IND_POSTDEC = 3'h7
    } asl_mode_t;
    // Access pipeline, Gray coded along idle -> read -> issue
    typedef enum logic [1:0] {
        ASL_IDLE = 2'b00,
        ASL_RDREG = 2'b01,
        ASL_ISSUE = 2'b11
    } asl_state_t;
endpackage

// *** pkg/asl_wreg_if.sv ***
// Carrier between the address logic and its working register file
`timescale 1ns/1ns
`default_nettype none
interface asl_wreg_if;
    logic [3:0] xsel; // X pointer / operand select
    logic [3:0] ysel; // Y pointer select
    logic [15:0] xval; // Registered X read data
    logic [15:0] yval; // Registered Y read data
    logic [15:0] spval; // Stack pointer, always visible
    logic we; // Write strobe
    logic [3:0] wsel; // Write select
    logic [15:0] wdata; // Write data
    modport core (output xsel, ysel, we, wsel, wdata,
                  input xval, yval, spval);
    modport file (input xsel, ysel, we, wsel, wdata,
                  output xval, yval, spval);
endinterface
`default_nettype wire

// *** core/asl_wreg.sv ***
// Sixteen-entry working register file with registered read ports
`timescale 1ns/1ns
`default_nettype none
module asl_wreg
(
    input wire logic mclk,
    input wire logic sys_rst,
    asl_wreg_if.file rf
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [asl_pkg::DW-1:0] mem_q [asl_pkg::NREG];

    // Write port; every register clears on reset
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < asl_pkg::NREG; i++)
                mem_q[i] <= asl_pkg::ZERO_W;
        end
        else if (rf.we)
            mem_q[rf.wsel] <= rf.wdata;
    end

    // Read data leave through registers, one cycle after select
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rf.xval <= asl_pkg::ZERO_W;
            rf.yval <= asl_pkg::ZERO_W;
            rf.spval <= asl_pkg::ZERO_W;
        end
        else
        begin
            rf.xval <= mem_q[rf.xsel];
            rf.yval <= mem_q[rf.ysel];
            rf.spval <= mem_q[asl_pkg::SP_IDX];
        end
    end
endmodule
`default_nettype wire

// *** verification/asl_core_properties.sv ***
// Port-level assertions for the core address space logic
`timescale 1ns/1ns
`default_nettype none
module asl_core_properties
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic fetch_en,
    input wire logic pc_load,
    input wire logic irq_take,
    input wire logic loop_start,
    input wire logic rpt_start,
    input wire logic dacc_req,
    input wire logic dacc_we,
    input wire logic [2:0] dacc_mode,
    input wire logic [15:0] dacc_lit,
    input wire logic [15:0] dacc_wdata,
    input wire logic dacc_mac,
    input wire logic mod_en,
    input wire logic brev_en,
    input wire logic [22:0] prog_addr,
    input wire logic prog_rd,
    input wire logic instr_valid,
    input wire logic [23:0] x_raddr,
    input wire logic x_rd,
    input wire logic [23:0] x_waddr,
    input wire logic x_wr,
    input wire logic [15:0] x_wdata,
    input wire logic y_rd,
    input wire logic dacc_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic fresh_q; // No fetch or redirect seen since reset
    logic vec_q; // Vector taken while fetch was idle
    logic drd; // Plain direct request in low data space
    // Modulo kept off so the direct address is unmodified
    assign drd = dacc_req && !dacc_busy && !mod_en && !dacc_lit[15]
        && dacc_mode == asl_pkg::ASL_DIRECT;
    // Track the first fetch after reset; vec_q below covers vectors
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            fresh_q <= 1'b1;
        else if (prog_rd | pc_load | irq_take | loop_start | rpt_start
                 | dacc_req)
            fresh_q <= 1'b0;
    end
    // Only idle-fetch vectors: an in-flight fetch keeps its old address
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            vec_q <= 1'b0;
        else if (irq_take)
            vec_q <= !fetch_en;
        else if (prog_rd | pc_load | dacc_req)
            vec_q <= 1'b0;
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_pc_even: assert property (prog_rd |-> !prog_addr[0])
        else $error("program address odd");
    a_reset_start: assert property (
        prog_rd && fresh_q |-> prog_addr == 23'h000000)
        else $error("first fetch not at zero");
    a_vec_region: assert property (
        prog_rd && vec_q |-> prog_addr < 23'h000200)
        else $error("vector fetch outside vector region");
    a_fetch_src: assert property (instr_valid |-> $past(prog_rd))
        else $error("instruction without program read");
    a_busy_take: assert property (
        dacc_req && !dacc_busy |=> dacc_busy)
        else $error("operand request not taken");
    a_direct_read: assert property (
        drd && !dacc_we && !brev_en |-> ##3 x_rd
        && x_raddr == {8'h00, $past(dacc_lit, 3)})
        else $error("direct read address wrong");
    a_brev_read: assert property (
        drd && !dacc_we && brev_en |-> ##3 x_rd && !x_wr
        && x_raddr == {8'h00, $past(dacc_lit, 3)})
        else $error("read address altered by reversal");
    a_write_path: assert property (
        drd && dacc_we && !brev_en |-> ##3 x_wr && !x_rd
        && x_wdata == $past(dacc_wdata, 3)
        && x_waddr == {8'h00, $past(dacc_lit, 3)})
        else $error("direct write wrong");
    a_mac_pair: assert property (y_rd |-> x_rd)
        else $error("Y read without X read");
    a_mac_issue: assert property (
        dacc_req && !dacc_busy && dacc_mac && !dacc_we |-> ##3 y_rd)
        else $error("dual read missing Y side");
    c_fetch: cover property (instr_valid);
    c_dual: cover property (x_rd && y_rd);
    c_write: cover property (x_wr);
endmodule
bind asl_core asl_core_properties u_asl_core_properties (.*);
`default_nettype wire

// *** verification/asl_mem_model.sv ***
// Program flash model answering the core's program port
`timescale 1ns/1ns
`default_nettype none
module asl_mem_model
(
    input wire logic mclk,
    input wire logic [22:0] prog_addr,
    input wire logic prog_rd,
    output logic [23:0] prog_rdata
);
    // full 24-bit word per even address, same cycle
    // Outside a read the port shows the inverse word
    always_comb
    begin
        prog_rdata = {prog_addr[7:0] ^ 8'h3c,
                      prog_addr[22:7] ^ prog_addr[15:0]};
        if (!prog_rd)
            prog_rdata = ~prog_rdata;
    end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the core address space logic
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic mclk, sys_rst, fetch_en, pc_load, slow_op, irq_take, sp_push;
    logic loop_start, rpt_start, prog_rd, instr_valid, dacc_req, dacc_we;
    logic dacc_mac, reg_we, win_en, mod_en, brev_en, x_rd, x_wr, y_rd;
    logic y_range_err, win_valid, dacc_busy;
    logic [22:0] pc_target, loop_end, prog_addr, t;
    logic [7:0] irq_vec, win_page, v8;
    logic [15:0] loop_count, rpt_count, dacc_lit, dacc_wdata, reg_wdata;
    logic [15:0] mod_start, mod_end, brev_mod, stack_addr, x_wdata, v, e;
    logic [15:0] y_raddr, win_data, operand, vy;
    logic [23:0] prog_rdata, instr_word, x_raddr, x_waddr, w;
    logic [2:0] dacc_mode;
    logic [3:0] dacc_reg, dacc_yreg, reg_wsel, k;
    logic [8:0] read_page_select, write_page_select;
    logic [23:0] q_ins[$], q_xa[$], q_ya[$], q_win[$]; // Expected notes
    int n_mismatch, compares, cyc;
    asl_pkg::asl_mode_t md[4] = '{asl_pkg::ASL_IND_POSTINC,
        asl_pkg::ASL_INDIRECT, asl_pkg::ASL_IND_POSTDEC,
        asl_pkg::ASL_INDIRECT};
    asl_core u_asl_core (.*);
    asl_mem_model u_asl_mem_model (.*);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] mw(input logic [22:0] a);
        return {a[7:0] ^ 8'h3c, a[22:7] ^ a[15:0]};
    endfunction
    // Empty queue yields unknown, so a stray result always mismatches
    function automatic logic [23:0] pop(ref logic [23:0] q[$]);
        return q.size() != 0 ? q.pop_front() : 24'hxxxxxx;
    endfunction
    task automatic chk(input string nm, input logic [23:0] ex,
                       input logic [23:0] got);
        compares++;
        if (got !== ex)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic fetch(input int n, input logic [22:0] a);
        for (int i = 0; i < n; i++)
            q_ins.push_back(mw(a + 23'(2 * i)));
        fetch_en = 1'b1;
        repeat (n) @(negedge mclk);
        fetch_en = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic wreg(input logic [3:0] r, input logic [15:0] d);
        {reg_we, reg_wsel, reg_wdata} = {1'b1, r, d};
        @(negedge mclk);
        reg_we = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    // One request, then idle well past the three-cycle spacing
    task automatic op(input logic we, input logic [2:0] m,
        input logic [3:0] r, input logic [15:0] l, input logic mac,
        input logic [3:0] yr);
        {dacc_we, dacc_mode, dacc_reg, dacc_lit} = {we, m, r, l};
        {dacc_mac, dacc_yreg, dacc_req} = {mac, yr, 1'b1};
        @(negedge mclk);
        dacc_req = 1'b0;
        repeat (4) @(negedge mclk);
    endtask
    // ------------------------------------------------------------
    // Clock, timeout and result watcher
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Whole run needs roughly 120 cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    always @(negedge mclk)
    begin
        if (sys_rst === 1'b0)
        begin
            if (instr_valid === 1'b1) chk("instr", pop(q_ins), instr_word);
            if (x_rd === 1'b1) chk("xaddr", pop(q_xa), x_raddr);
            if (y_rd === 1'b1) chk("yaddr", pop(q_ya), {8'h00, y_raddr});
            if (win_valid === 1'b1) chk("win", pop(q_win), {8'h00, win_data});
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {fetch_en, pc_load, slow_op, irq_take, sp_push, loop_start} = '0;
        {rpt_start, dacc_req, dacc_we, dacc_mac, reg_we, win_en} = '0;
        {mod_en, brev_en, pc_target, irq_vec, win_page, dacc_lit} = '0;
        {dacc_wdata, reg_wdata, dacc_mode, dacc_reg, dacc_yreg} = '0;
        reg_wsel = 4'h0;
        sys_rst = 1'b1;
        void'($urandom(32'h0b50));
        {read_page_select, write_page_select, mod_start, mod_end, brev_mod,
         loop_end, loop_count, rpt_count} = 121'({$urandom, $urandom,
         $urandom, $urandom});
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        chk("stack", 24'h000000, {8'h00, stack_addr});
        fetch(4, 23'h000000);
        // Jump target then straight-line steps
        t = 23'($urandom) & 23'h7ffffe;
        {pc_target, pc_load} = {t, 1'b1};
        @(negedge mclk);
        pc_load = 1'b0;
        @(negedge mclk);
        fetch(3, t);
        // Lowest, highest and a random vector
        for (int i = 0; i < 3; i++)
        begin
            v8 = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom);
            {irq_vec, irq_take} = {v8, 1'b1};
            @(negedge mclk);
            irq_take = 1'b0;
            @(negedge mclk);
            fetch(2, {14'h0000, v8, 1'b0});
        end
        // Pointer modes with post-update; reversal must not touch reads
        k = 4'($urandom_range(14, 3));
        v = (16'($urandom) & 16'h7ff0) | 16'h0010;
        wreg(k, v);
        brev_en = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            q_xa.push_back({8'h00, v + ((i == 1 || i == 2) ? 16'h2 : 16'h0)});
            op(1'b0, md[i], k, 16'h0000, 1'b0, 4'h0);
        end
        for (int b = 0; b < 2; b++)
        begin
            brev_en = b[0];
            e = 16'($urandom) & 16'h7ffe;
            q_xa.push_back({8'h00, e});
            op(1'b0, asl_pkg::ASL_DIRECT, 4'h0, e, 1'b0, 4'h0);
        end
        brev_en = 1'b0;
        dacc_wdata = 16'($urandom);
        op(1'b1, asl_pkg::ASL_DIRECT, 4'h0, e ^ 16'h0ff0, 1'b0, 4'h0);
        // Dual read: X pointer in k, Y pointer in register two
        vy = 16'h9000 | (16'($urandom) & 16'h0ffe);
        wreg(4'h2, vy);
        q_xa.push_back({8'h00, v});
        q_ya.push_back({8'h00, vy});
        op(1'b0, asl_pkg::ASL_INDIRECT, k, 16'h0000, 1'b1, 4'h2);
        // Circular post-increment at the top bound wraps to the bottom
        {mod_en, mod_start, mod_end} = {1'b1, v - 16'h4, v};
        for (int i = 0; i < 2; i++)
        begin
            q_xa.push_back({8'h00, v - 16'(4 * i)});
            op(1'b0, md[i], k, 16'h0000, 1'b0, 4'h0);
        end
        mod_en = 1'b0;
        // Upper data half read through the program window
        e = 16'h8000 | (16'($urandom) & 16'h7ffe);
        wreg(4'h1, e);
        {win_en, win_page} = {1'b1, 8'($urandom)};
        w = mw({win_page, e[14:0]});
        q_win.push_back({8'h00, w[15:0]});
        op(1'b0, asl_pkg::ASL_INDIRECT, 4'h1, 16'h0000, 1'b0, 4'h0);
        win_en = 1'b0;
        q_xa.push_back({read_page_select, e[14:0]});
        op(1'b0, asl_pkg::ASL_DIRECT, 4'h0, e, 1'b0, 4'h0);
        repeat (3) @(negedge mclk);
        // Two pushes move the stack pointer by four
        for (int i = 0; i < 2; i++)
        begin
            sp_push = 1'b1;
            @(negedge mclk);
            sp_push = 1'b0;
            @(negedge mclk);
        end
        repeat (4) @(negedge mclk);
        chk("stack", 24'h000004, {8'h00, stack_addr});
        chk("pending", 24'h000000, 24'(q_ins.size() + q_xa.size()
            + q_ya.size() + q_win.size()));
        tally_and_finish();
    end
endmodule
`default_nettype wire
